// ### core/dtc_pkg.sv
// constants, types and helpers for the dual timer with capture and pwm
// Behaviour
// - timer zero clock field: osc/4096, /256, /8, or external clock pin
// - timer one clock field: osc/4, /8, /16, or counter A toggle flop
// - mode 00 is interval timer; counter clears on reference match
// - timer zero modes 01/10 capture rising/falling edges; counter runs, overflow allowed
// - timer zero mode 11 is pwm; match and overflow events both possible
// - timer one modes 01/10/11 capture rising, falling, both edges; counter runs
// - writing 1 to control bit 3 clears that counter; 0 does nothing
// - control bit 2 enables that timer's overflow interrupt request
// - control bit 1 enables that timer's match/capture interrupt request
// - bit 0 reads pending flag; writing 0 clears it, 1 does nothing
// - overflow pending clears by itself in hardware
`default_nettype none
package dtc_pkg;
    // =====================================================
    // register map
    localparam logic [7:0] OFS_CTL0 = 8'hd2;
    localparam logic [7:0] OFS_CTL1 = 8'hfa;
    localparam logic [7:0] OFS_CNT0 = 8'hd0;
    localparam logic [7:0] OFS_DAT0 = 8'hd1;
    localparam logic [7:0] OFS_CNT1 = 8'hf8;
    localparam logic [7:0] OFS_DAT1 = 8'hf9;
    localparam logic [7:0] CTL_RST  = 8'h00;
    localparam logic [7:0] RD_NONE  = 8'h00;
    // =====================================================
    // control fields
    localparam int CS_HI    = 7;
    localparam int CS_LO    = 6;
    localparam int MD_HI    = 5;
    localparam int MD_LO    = 4;
    localparam int CLR_BIT  = 3;
    localparam int OVIE_BIT = 2;
    localparam int MCIE_BIT = 1;
    localparam int PND_BIT  = 0;
    localparam logic [1:0] CS_DIV_A = 2'b00;
    localparam logic [1:0] CS_DIV_B = 2'b01;
    localparam logic [1:0] CS_DIV_C = 2'b10;
    localparam logic [1:0] CS_SRC   = 2'b11;
    // =====================================================
    // widths and prescaler taps (log2 of divide ratio)
    localparam int CNT_W  = 8;
    localparam int PRE_W  = 12;
    localparam int T0_TAP_A = 12;
    localparam int T0_TAP_B = 8;
    localparam int T0_TAP_C = 3;
    localparam int T1_TAP_A = 2;
    localparam int T1_TAP_B = 3;
    localparam int T1_TAP_C = 4;
    typedef enum logic [1:0] {
        DTC_MD_INTERVAL = 2'b00,
        DTC_MD_RISE     = 2'b01,
        DTC_MD_FALL     = 2'b10,
        DTC_MD_TOP      = 2'b11
    } dtc_mode_t;
    // true once every 2**n oscillator cycles
    function automatic logic dtc_tap(input logic [PRE_W-1:0] pre, input int unsigned n);
        logic [PRE_W-1:0] m;
        m = PRE_W'((1 << n) - 1);
        return (pre & m) == m;
    endfunction
endpackage
`default_nettype wire

// ### core/dtc_chan_if.sv
// channel carrier between the register side and one timer channel
`timescale 1ns/10ps
`default_nettype none
interface dtc_chan_if #(parameter int W = 8);
    logic              tick;
    logic              rise;
    logic              fall;
    dtc_pkg::dtc_mode_t mode;
    logic              clr;
    logic              dat_wr;
    logic [W-1:0]      wdata;
    logic [W-1:0]      cnt;
    logic [W-1:0]      dat;
    logic              match_ev;
    logic              ovf_ev;
    logic              cap_ev;
    logic              pwm;
    modport ctl  (output tick, rise, fall, mode, clr, dat_wr, wdata,
                  input cnt, dat, match_ev, ovf_ev, cap_ev, pwm);
    modport chan (input tick, rise, fall, mode, clr, dat_wr, wdata,
                  output cnt, dat, match_ev, ovf_ev, cap_ev, pwm);
endinterface
`default_nettype wire

// ### core/dtc_chan.sv
// one timer channel: counter, reference/capture register, events
`timescale 1ns/10ps
`default_nettype none
module dtc_chan #(
    parameter int W          = 8,
    parameter bit BOTH_EDGES = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_b,
    dtc_chan_if.chan  c
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] dat_reg;
    logic         match_reg;
    logic         ovf_reg;
    logic         cap_reg;
    logic         pwm_reg;
    logic         at_ref;
    logic         at_max;
    logic         match_hit;
    logic         cap_hit;
    logic         clr_on_match;

    // =====================================================
    // mode decode
    always_comb begin
        at_ref       = (cnt_reg == dat_reg);
        at_max       = (cnt_reg == {W{1'b1}});
        match_hit    = 1'b0;
        cap_hit      = 1'b0;
        clr_on_match = 1'b0;
        unique case (c.mode)
            dtc_pkg::DTC_MD_INTERVAL: begin
                match_hit    = c.tick && at_ref;
                clr_on_match = match_hit;
            end
            dtc_pkg::DTC_MD_RISE: cap_hit = c.rise;
            dtc_pkg::DTC_MD_FALL: cap_hit = c.fall;
            dtc_pkg::DTC_MD_TOP: begin
                if (BOTH_EDGES) begin
                    cap_hit = c.rise || c.fall;
                end else begin
                    match_hit = c.tick && at_ref;
                end
            end
        endcase
    end

    // =====================================================
    // counter; a software clear beats a same-cycle tick
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_reg <= '0;
        end else if (c.clr) begin
            cnt_reg <= '0;
        end else if (c.tick) begin
            cnt_reg <= clr_on_match ? '0 : cnt_reg + W'(1);
        end
    end

    // capture wins over a cpu write landing in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dat_reg <= '0;
        end else if (cap_hit) begin
            dat_reg <= cnt_reg;
        end else if (c.dat_wr) begin
            dat_reg <= c.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            match_reg <= 1'b0;
            ovf_reg   <= 1'b0;
            cap_reg   <= 1'b0;
            pwm_reg   <= 1'b0;
        end else begin
            match_reg <= match_hit;
            ovf_reg   <= c.tick && at_max && !clr_on_match && !c.clr;
            cap_reg   <= cap_hit;
            pwm_reg   <= !BOTH_EDGES && (c.mode == dtc_pkg::DTC_MD_TOP)
                         && (cnt_reg < dat_reg);
        end
    end

    assign c.cnt      = cnt_reg;
    assign c.dat      = dat_reg;
    assign c.match_ev = match_reg;
    assign c.ovf_ev   = ovf_reg;
    assign c.cap_ev   = cap_reg;
    assign c.pwm      = pwm_reg;
endmodule
`default_nettype wire

// ### core/dtc_top.sv
// dual timer top: control registers, clock selection, pin sync, interrupts
`timescale 1ns/10ps
`default_nettype none
module dtc_top (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       timer_zero_ext_clock_pin,
    input  wire logic       timer_zero_capture_pin,
    input  wire logic       timer_one_capture_pin,
    input  wire logic       counter_a_toggle_flop,
    output logic      [1:0] match_irq,
    output logic      [1:0] ovf_irq,
    output logic            timer_zero_pwm
);
    logic [dtc_pkg::PRE_W-1:0] pre_reg;
    logic [2:0]                ext_sync_reg;
    logic [2:0]                cap0_sync_reg;
    logic [2:0]                cap1_sync_reg;
    logic                      tff_prev_reg;
    logic [7:0]                rdata_reg;
    logic                      ext_rise;
    logic                      tff_rise;

    // =====================================================
    // prescaler and pin synchronisers
    // taps read bit [2] and [1] only, never the first stage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pre_reg       <= '0;
            ext_sync_reg  <= '0;
            cap0_sync_reg <= '0;
            cap1_sync_reg <= '0;
            tff_prev_reg  <= 1'b0;
        end else begin
            pre_reg       <= pre_reg + dtc_pkg::PRE_W'(1);
            ext_sync_reg  <= {ext_sync_reg[1:0], timer_zero_ext_clock_pin};
            cap0_sync_reg <= {cap0_sync_reg[1:0], timer_zero_capture_pin};
            cap1_sync_reg <= {cap1_sync_reg[1:0], timer_one_capture_pin};
            tff_prev_reg  <= counter_a_toggle_flop;
        end
    end
    assign ext_rise = ext_sync_reg[1] && !ext_sync_reg[2];
    // toggle flop runs on this clock, so no synchroniser
    assign tff_rise = counter_a_toggle_flop && !tff_prev_reg;

    // =====================================================
    // per-timer control and channel
    for (genvar i = 0; i < 2; i++) begin : g_tmr
        dtc_chan_if #(.W(dtc_pkg::CNT_W)) cif ();
        logic [7:0] ctl_reg;
        logic       ovf_irq_reg;
        logic       match_irq_reg;
        logic [1:0] cs;
        logic       ctl_wr;
        logic [2:0] cap_s;
        logic       src_tick;

        assign cs     = ctl_reg[dtc_pkg::CS_HI:dtc_pkg::CS_LO];
        assign ctl_wr = reg_wr && (reg_addr == (i == 0 ? dtc_pkg::OFS_CTL0 : dtc_pkg::OFS_CTL1));
        assign cap_s  = (i == 0) ? cap0_sync_reg : cap1_sync_reg;

        always_comb begin
            if (i == 0) begin
                unique case (cs)
                    dtc_pkg::CS_DIV_A: src_tick = dtc_pkg::dtc_tap(pre_reg, dtc_pkg::T0_TAP_A);
                    dtc_pkg::CS_DIV_B: src_tick = dtc_pkg::dtc_tap(pre_reg, dtc_pkg::T0_TAP_B);
                    dtc_pkg::CS_DIV_C: src_tick = dtc_pkg::dtc_tap(pre_reg, dtc_pkg::T0_TAP_C);
                    dtc_pkg::CS_SRC:   src_tick = ext_rise;
                endcase
            end else begin
                unique case (cs)
                    dtc_pkg::CS_DIV_A: src_tick = dtc_pkg::dtc_tap(pre_reg, dtc_pkg::T1_TAP_A);
                    dtc_pkg::CS_DIV_B: src_tick = dtc_pkg::dtc_tap(pre_reg, dtc_pkg::T1_TAP_B);
                    dtc_pkg::CS_DIV_C: src_tick = dtc_pkg::dtc_tap(pre_reg, dtc_pkg::T1_TAP_C);
                    dtc_pkg::CS_SRC:   src_tick = tff_rise;
                endcase
            end
        end

        assign cif.tick   = src_tick;
        assign cif.rise   = cap_s[1] && !cap_s[2];
        assign cif.fall   = !cap_s[1] && cap_s[2];
        assign cif.mode   = dtc_pkg::dtc_mode_t'(ctl_reg[dtc_pkg::MD_HI:dtc_pkg::MD_LO]);
        assign cif.clr    = ctl_wr && reg_wdata[dtc_pkg::CLR_BIT];
        assign cif.dat_wr = reg_wr && (reg_addr == (i == 0 ? dtc_pkg::OFS_DAT0 : dtc_pkg::OFS_DAT1));
        assign cif.wdata  = reg_wdata;

        dtc_chan #(
            .W          (dtc_pkg::CNT_W),
            .BOTH_EDGES (i == 1)
        ) u_chan (
            .clk   (clk),
            .rst_b (rst_b),
            .c     (cif.chan)
        );

        // clear bit is a strobe and is never stored, so it reads 0
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                ctl_reg <= dtc_pkg::CTL_RST;
            end else begin
                if (ctl_wr) begin
                    ctl_reg[dtc_pkg::CS_HI:dtc_pkg::MD_LO] <=
                        reg_wdata[dtc_pkg::CS_HI:dtc_pkg::MD_LO];
                    ctl_reg[dtc_pkg::OVIE_BIT] <= reg_wdata[dtc_pkg::OVIE_BIT];
                    ctl_reg[dtc_pkg::MCIE_BIT] <= reg_wdata[dtc_pkg::MCIE_BIT];
                end
                // a new event beats a software clear in the same cycle
                if (cif.match_ev || cif.cap_ev) begin
                    ctl_reg[dtc_pkg::PND_BIT] <= 1'b1;
                end else if (ctl_wr && !reg_wdata[dtc_pkg::PND_BIT]) begin
                    ctl_reg[dtc_pkg::PND_BIT] <= 1'b0;
                end
            end
        end

        // overflow request is a single pulse: nothing for software to clear
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                ovf_irq_reg   <= 1'b0;
                match_irq_reg <= 1'b0;
            end else begin
                ovf_irq_reg   <= cif.ovf_ev && ctl_reg[dtc_pkg::OVIE_BIT];
                match_irq_reg <= ctl_reg[dtc_pkg::PND_BIT]
                                 && ctl_reg[dtc_pkg::MCIE_BIT];
            end
        end
        assign ovf_irq[i]   = ovf_irq_reg;
        assign match_irq[i] = match_irq_reg;
    end

    // =====================================================
    // register read port, answer one cycle after the address
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_reg <= dtc_pkg::RD_NONE;
        end else begin
            unique case (reg_addr)
                dtc_pkg::OFS_CTL0: rdata_reg <= g_tmr[0].ctl_reg;
                dtc_pkg::OFS_CTL1: rdata_reg <= g_tmr[1].ctl_reg;
                dtc_pkg::OFS_CNT0: rdata_reg <= g_tmr[0].cif.cnt;
                dtc_pkg::OFS_DAT0: rdata_reg <= g_tmr[0].cif.dat;
                dtc_pkg::OFS_CNT1: rdata_reg <= g_tmr[1].cif.cnt;
                dtc_pkg::OFS_DAT1: rdata_reg <= g_tmr[1].cif.dat;
                default:           rdata_reg <= dtc_pkg::RD_NONE;
            endcase
        end
    end
    assign reg_rdata      = rdata_reg;
    assign timer_zero_pwm = g_tmr[0].cif.pwm;

    // =====================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_t0_ref_tick;
        g_tmr[0].cif.tick && !g_tmr[0].cif.clr
        && g_tmr[0].cif.cnt == g_tmr[0].cif.dat;
    endsequence
    sequence s_t0_cleared_flagged;
        g_tmr[0].cif.cnt == '0 && g_tmr[0].cif.match_ev;
    endsequence

    property p_t0_div;
        g_tmr[0].cs == dtc_pkg::CS_DIV_B && g_tmr[0].cif.tick |-> pre_reg[7:0] == 8'hff;
    endproperty
    a_t0_div: assert property (p_t0_div) else $error("t0 tick off prescale");
    property p_t1_div;
        g_tmr[1].cs == dtc_pkg::CS_DIV_C && g_tmr[1].cif.tick |-> pre_reg[3:0] == 4'hf;
    endproperty
    a_t1_div: assert property (p_t1_div) else $error("t1 tick off prescale");
    property p_interval;
        g_tmr[0].cif.mode == dtc_pkg::DTC_MD_INTERVAL and s_t0_ref_tick
        |=> s_t0_cleared_flagged;
    endproperty
    a_interval: assert property (p_interval) else $error("interval match lost");
    property p_pwm_match;
        g_tmr[0].cif.mode == dtc_pkg::DTC_MD_TOP and s_t0_ref_tick
        |=> g_tmr[0].cif.match_ev ##1 g_tmr[0].ctl_reg[0];
    endproperty
    a_pwm_match: assert property (p_pwm_match) else $error("pwm match lost");
    property p_both_edges;
        g_tmr[1].cif.mode == dtc_pkg::DTC_MD_TOP && g_tmr[1].cif.fall
        |=> g_tmr[1].cif.cap_ev && g_tmr[1].cif.dat == $past(g_tmr[1].cif.cnt);
    endproperty
    a_both_edges: assert property (p_both_edges) else $error("t1 edge capture lost");
    property p_clear;
        g_tmr[1].cif.clr |=> g_tmr[1].cif.cnt == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("counter clear failed");
    property p_ovf_gate;
        g_tmr[0].cif.ovf_ev |=> ovf_irq[0] == $past(g_tmr[0].ctl_reg[2]) ##1
        !ovf_irq[0];
    endproperty
    a_ovf_gate: assert property (p_ovf_gate) else $error("overflow irq wrong");
    property p_match_irq;
        g_tmr[1].ctl_reg[0] && g_tmr[1].ctl_reg[1] [*2] |-> match_irq[1];
    endproperty
    a_match_irq: assert property (p_match_irq) else $error("match irq not raised");
    property p_pend_clr;
        g_tmr[0].ctl_wr && !reg_wdata[0] && !g_tmr[0].cif.match_ev && !g_tmr[0].cif.cap_ev
        |=> !g_tmr[0].ctl_reg[0] ##1 !match_irq[0];
    endproperty
    a_pend_clr: assert property (p_pend_clr) else $error("pending not cleared");
    property p_count;
        g_tmr[0].cif.tick && !g_tmr[0].cif.clr && g_tmr[0].cif.mode == dtc_pkg::DTC_MD_RISE
        |=> g_tmr[0].cif.cnt == $past(g_tmr[0].cif.cnt) + 8'h01;
    endproperty
    a_count: assert property (p_count) else $error("counter did not step");
endmodule
`default_nettype wire

// ### tb/dtc_pin_model.sv
// far-side pin model: external clock pin and the two capture pins
`timescale 1ns/10ps
`default_nettype none
module dtc_pin_model (
    input  wire logic clk,
    output logic      ext_clk,
    output logic      cap0,
    output logic      cap1
);
    // =====================================================
    // idle levels
    initial begin
        ext_clk = 1'b0;
        cap0    = 1'b0;
        cap1    = 1'b0;
    end
    // =====================================================
    // bursts: pin rests low between bursts, each level held two cycles
    // so the two-flop synchroniser cannot miss it
    task automatic ext_pulses(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk) ext_clk <= 1'b1;
            @(posedge clk);
            @(posedge clk) ext_clk <= 1'b0;
            @(posedge clk);
        end
    endtask
    task automatic set_cap(input bit t, input logic v);
        @(posedge clk);
        if (t) cap1 <= v;
        else cap0 <= v;
    endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the dual timer block
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct packed {logic [7:0] a; bit wr; logic [7:0] d; logic [7:0] e;} dtc_row_t;
    typedef struct packed {bit t; logic [1:0] cs; logic [7:0] dat; int per;} dtc_per_t;
    typedef struct packed {bit t; logic [1:0] m;} dtc_cap_t;
    logic       clk;
    logic       rst_b;
    logic [7:0] reg_addr;
    logic       reg_wr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       ext_clk;
    logic       cap0;
    logic       cap1;
    logic       tff;
    logic [1:0] match_irq;
    logic [1:0] ovf_irq;
    logic       pwm;
    int         num_errors = 0;
    int         n_checks = 0;
    int         cyc = 0;
    // timer one idles in interval mode with data 0 from reset, so its flag is
    // already up when row two writes; the 1 written to bit 0 must leave it set
    dtc_row_t rows [9] = '{'{8'hd2, 1, 8'hff, 8'hf6}, '{8'hfa, 1, 8'hff, 8'hf7},
        '{8'hd1, 1, 8'h5a, 8'h5a}, '{8'hf9, 1, 8'ha5, 8'ha5}, '{8'hd0, 1, 8'h33, 8'h00},
        '{8'hf8, 1, 8'h44, 8'h00}, '{8'h55, 1, 8'h12, 8'h00}, '{8'hd2, 1, 8'hc0, 8'hc0},
        '{8'hfa, 1, 8'hc0, 8'hc0}};
    dtc_per_t pers [6] = '{'{0, 2'b00, 8'h00, 4096}, '{0, 2'b01, 8'h01, 512},
        '{0, 2'b10, 8'h03, 32}, '{1, 2'b00, 8'h03, 16}, '{1, 2'b01, 8'h01, 16},
        '{1, 2'b10, 8'h02, 48}};
    dtc_cap_t caps [5] = '{'{0, 2'b01}, '{0, 2'b10}, '{1, 2'b01}, '{1, 2'b10}, '{1, 2'b11}};

    dtc_top dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .timer_zero_ext_clock_pin(ext_clk),
        .timer_zero_capture_pin(cap0), .timer_one_capture_pin(cap1),
        .counter_a_toggle_flop(tff), .match_irq(match_irq), .ovf_irq(ovf_irq),
        .timer_zero_pwm(pwm));
    dtc_pin_model pm_u (.clk(clk), .ext_clk(ext_clk), .cap0(cap0), .cap1(cap1));

    // =====================================================
    // clock, timeout (longest test is two periods of the /4096 tap)
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            end_sim();
        end
    end
    // =====================================================
    // tasks
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic checkn(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wr    <= 1'b1;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data follows the address by one edge; sampled mid-cycle
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        @(negedge clk);
        check8(reg_rdata, exp);
    endtask
    // sel 0/1 match request, 2/3 overflow request
    task automatic wait_on(input int sel, input logic lvl, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (((({ovf_irq, match_irq} >> sel) & 4'h1) !== {3'h0, lvl}) && n < lim);
        checkn(int'(n < lim), 1);
    endtask
    task automatic ticks(input bit t, input int n);
        if (!t) pm_u.ext_pulses(n);
        else begin
            for (int i = 0; i < n; i++) begin
                @(posedge clk) tff <= 1'b1;
                @(posedge clk) tff <= 1'b0;
                @(posedge clk);
            end
        end
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    // =====================================================
    // main sequence
    initial begin
        logic [7:0] ca;
        logic [7:0] da;
        logic       rise;
        logic       fall;
        int         t0;
        int         n;
        clk = 1'b0;
        rst_b = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        tff = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) reg_write(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        $display("test registers done");
        foreach (pers[i]) begin
            ca = pers[i].t ? dtc_pkg::OFS_CTL1 : dtc_pkg::OFS_CTL0;
            da = pers[i].t ? dtc_pkg::OFS_DAT1 : dtc_pkg::OFS_DAT0;
            reg_write(da, pers[i].dat);
            reg_write(ca, {pers[i].cs, 6'h0a});
            wait_on(pers[i].t, 1'b1, 2 * pers[i].per + 16);
            t0 = cyc;
            reg_write(ca, {pers[i].cs, 6'h02});
            wait_on(pers[i].t, 1'b0, 8);
            wait_on(pers[i].t, 1'b1, pers[i].per + 16);
            checkn(cyc - t0, pers[i].per);
            reg_write(ca, 8'hc0);
        end
        $display("test interval done");
        reg_write(dtc_pkg::OFS_CTL1, 8'h1c);
        wait_on(3, 1'b1, 1100);
        t0 = cyc;
        @(negedge clk);
        check8({7'h0, ovf_irq[1]}, 8'h00);
        wait_on(3, 1'b1, 1100);
        checkn(cyc - t0, 1024);
        reg_write(dtc_pkg::OFS_CTL1, 8'h10);
        n = 0;
        repeat (1100) begin
            @(negedge clk);
            if (ovf_irq[1] !== 1'b0) n++;
        end
        checkn(n, 0);
        reg_write(dtc_pkg::OFS_CTL1, 8'hc0);
        // timer zero free-runs at /8 so its overflow comes within 2048 cycles
        reg_write(dtc_pkg::OFS_CTL0, 8'h9c);
        wait_on(2, 1'b1, 2100);
        @(negedge clk);
        check8({7'h0, ovf_irq[0]}, 8'h00);
        reg_write(dtc_pkg::OFS_CTL0, 8'hc0);
        $display("test overflow done");
        foreach (caps[i]) begin
            rise = (caps[i].m == 2'b01) || (caps[i].t && caps[i].m == 2'b11);
            fall = (caps[i].m == 2'b10) || (caps[i].t && caps[i].m == 2'b11);
            ca = caps[i].t ? dtc_pkg::OFS_CTL1 : dtc_pkg::OFS_CTL0;
            da = caps[i].t ? dtc_pkg::OFS_DAT1 : dtc_pkg::OFS_DAT0;
            reg_write(da, 8'h00);
            reg_write(ca, {2'b11, caps[i].m, 4'ha});
            ticks(caps[i].t, 3);
            pm_u.set_cap(caps[i].t, 1'b1);
            repeat (8) @(negedge clk);
            check8({7'h0, match_irq[caps[i].t]}, {7'h0, rise});
            rd_chk(da, rise ? 8'h03 : 8'h00);
            rd_chk(ca, {2'b11, caps[i].m, 3'b001, rise});
            reg_write(ca, {2'b11, caps[i].m, 4'h2});
            ticks(caps[i].t, 2);
            pm_u.set_cap(caps[i].t, 1'b0);
            repeat (8) @(negedge clk);
            rd_chk(da, fall ? 8'h05 : (rise ? 8'h03 : 8'h00));
            rd_chk(ca, {2'b11, caps[i].m, 3'b001, fall});
        end
        $display("test capture done");
        reg_write(dtc_pkg::OFS_DAT0, 8'h03);
        reg_write(dtc_pkg::OFS_CTL0, 8'hf8);
        ticks(0, 2);
        check8({7'h0, pwm}, 8'h01);
        ticks(0, 1);
        check8({7'h0, pwm}, 8'h00);
        ticks(0, 1);
        rd_chk(dtc_pkg::OFS_CTL0, 8'hf1);
        check8({7'h0, match_irq[0]}, 8'h00);
        reg_write(dtc_pkg::OFS_CTL0, 8'hf0);
        rd_chk(dtc_pkg::OFS_CTL0, 8'hf0);
        $display("test pwm done");
        reg_write(dtc_pkg::OFS_CTL1, 8'hd8);
        ticks(1, 5);
        rd_chk(dtc_pkg::OFS_CNT1, 8'h05);
        reg_write(dtc_pkg::OFS_CTL1, 8'hd0);
        reg_write(dtc_pkg::OFS_CNT1, 8'h77);
        rd_chk(dtc_pkg::OFS_CNT1, 8'h05);
        reg_write(dtc_pkg::OFS_CTL1, 8'hd8);
        rd_chk(dtc_pkg::OFS_CNT1, 8'h00);
        $display("test counter clear done");
        reg_write(dtc_pkg::OFS_CTL0, 8'hc6);
        @(posedge clk) rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(dtc_pkg::OFS_CTL0, 8'h00);
        rd_chk(dtc_pkg::OFS_CTL1, 8'h00);
        $display("test reset done");
        end_sim();
    end
endmodule
`default_nettype wire
